// ===== shared/ladder_ref_pkg.sv
/*
 package for the ladder reference control block: register map, field layout,
 reset values and the state carriers. assumes a 32-bit AXI4-Lite register bus.
*/
package ladder_ref_pkg;
    localparam logic [11:0] REFERENCE_CONTROL_OFFSET = 12'h09f;
    localparam logic [11:0] PORT_A_DIRECTION_OFFSET = 12'h0a0;
    // offsets are register indices; the bus byte address is four times the index
    localparam logic [11:0] REFERENCE_CONTROL_ADDR = {REFERENCE_CONTROL_OFFSET[9:0], 2'b00};
    localparam logic [11:0] PORT_A_DIRECTION_ADDR = {PORT_A_DIRECTION_OFFSET[9:0], 2'b00};
    localparam int POWER_BIT = 7;
    localparam int PIN_OUT_BIT = 6;
    localparam int RANGE_BIT = 5;
    localparam int UNUSED_BIT = 4;
    localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] WRITE_MASK = 8'hef;
    localparam logic [7:0] PORT_A_DIRECTION_RESET = 8'hff;
    localparam int PIN2_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_HAVE = 3'b010,
        WR_RESP = 3'b100
    } wr_state_t;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] direction;
    } ladder_regs_t;

    typedef struct packed {
        logic power_on;
        logic range_low;
        logic [3:0] tap;
        logic pin_connect;
        logic pin_direction_in;
    } ladder_out_t;
endpackage

// ===== rtl/ladder_decode.sv
/*
 decodes the stored control byte into ladder controls.
 assumes next-state inputs from the same clock domain; the result is registered by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module ladder_decode
    import ladder_ref_pkg::*;
(
    input wire logic [7:0] i_control,
    input wire logic i_direction_pin2,
    output var ladder_out_t o_out
);
    always_comb begin
        o_out.power_on = i_control[POWER_BIT];
        o_out.range_low = i_control[RANGE_BIT];
        o_out.tap = i_control[3:0];
        o_out.pin_connect = i_control[PIN_OUT_BIT] & i_direction_pin2;
        o_out.pin_direction_in = i_direction_pin2;
    end
endmodule // ladder_decode
`default_nettype wire

// ===== rtl/ladder_reference_control.sv
/*
 ladder reference control: reference_control and port direction registers
 behind an AXI4-Lite slave, driving the ladder power, range, tap and pin gate.
 assumes a single 100 MHz clock and synchronous active-high reset.
*/
// Contract
// - bit 7 powers the ladder when set, powers it down when clear, and reset clears it.
// - the reference reaches the analog output pin only while bit 6 and port A pin 2 direction are both set.
// - bit 5 selects the low range when 1 and the high range when 0.
// - bits 3 to 0 pick the ladder tap, code/24 of supply low range, 1/4 plus code/32 high range.
// - reset also clears the pin-output enable, range bit and tap code.
// - wake from sleep leaves every bit of reference_control unchanged.
// - the settings act regardless of the comparator configuration.
`timescale 1ns/10ps
`default_nettype none
module ladder_reference_control
    import ladder_ref_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sleep_wake,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic o_ladder_power_enable,
    output logic o_ladder_range_low_select,
    output logic [3:0] o_ladder_tap_code,
    output logic o_analog_output_pin_connect,
    output logic o_port_a_pin2_direction
);
    typedef struct packed {
        ladder_regs_t regs;
        wr_state_t wst;
        logic aw_have;
        logic w_have;
        logic [11:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic bvalid;
        ladder_out_t out;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    ladder_out_t dec;
    logic unused_inputs;

    assign unused_inputs = ^{s_axi_wdata[31:8], s_axi_wstrb[3:1], i_sleep_wake};

    ladder_decode u_decode (
        .i_control(st_nxt.regs.control),
        .i_direction_pin2(st_nxt.regs.direction[PIN2_BIT]),
        .o_out(dec)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        // write channel capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wstrb0 = s_axi_wstrb[0];
        end
        unique case (st_r.wst)
            WR_IDLE, WR_HAVE: begin
                if (st_r.aw_have && st_r.w_have) begin
                    st_nxt.aw_have = 1'b0;
                    st_nxt.w_have = 1'b0;
                    st_nxt.bresp = RESP_OKAY;
                    st_nxt.wst = WR_RESP;
                    if (st_r.awaddr == REFERENCE_CONTROL_ADDR) begin
                        if (st_r.wstrb0) begin
                            st_nxt.regs.control = st_r.wdata & WRITE_MASK;
                        end
                    end else if (st_r.awaddr == PORT_A_DIRECTION_ADDR) begin
                        if (st_r.wstrb0) begin
                            st_nxt.regs.direction = st_r.wdata;
                        end
                    end else begin
                        st_nxt.bresp = RESP_SLVERR;
                    end
                end else if (st_nxt.aw_have || st_nxt.w_have) begin
                    st_nxt.wst = WR_HAVE;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    st_nxt.wst = WR_IDLE;
                end
            end
        endcase
        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            if (s_axi_araddr == REFERENCE_CONTROL_ADDR) begin
                st_nxt.rdata = st_r.regs.control & WRITE_MASK;
            end else if (s_axi_araddr == PORT_A_DIRECTION_ADDR) begin
                st_nxt.rdata = st_r.regs.direction;
            end else begin
                st_nxt.rdata = 8'h00;
                st_nxt.rresp = RESP_SLVERR;
            end
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        // sleep wake touches nothing here; comparator state is not an input
        st_nxt.out = dec;
        // handshake outputs held in flops, derived from the next state
        st_nxt.aw_rdy = ~st_nxt.aw_have & (st_nxt.wst != WR_RESP);
        st_nxt.w_rdy = ~st_nxt.w_have & (st_nxt.wst != WR_RESP);
        st_nxt.bvalid = st_nxt.wst == WR_RESP;
        st_nxt.ar_rdy = ~st_nxt.rvalid;
        if (i_rst) begin
            st_nxt = '0;
            st_nxt.wst = WR_IDLE;
            st_nxt.regs.control = REFERENCE_CONTROL_RESET;
            st_nxt.regs.direction = PORT_A_DIRECTION_RESET;
            st_nxt.out.pin_direction_in = PORT_A_DIRECTION_RESET[PIN2_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // readies low through reset, raised one edge after release
    assign s_axi_awready = st_r.aw_rdy;
    assign s_axi_wready = st_r.w_rdy;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.ar_rdy;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = {24'h000000, st_r.rdata};
    assign s_axi_rresp = st_r.rresp;
    assign o_ladder_power_enable = st_r.out.power_on;
    assign o_ladder_range_low_select = st_r.out.range_low;
    assign o_ladder_tap_code = st_r.out.tap;
    assign o_analog_output_pin_connect = st_r.out.pin_connect;
    assign o_port_a_pin2_direction = st_r.out.pin_direction_in;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence ctl_write_s;
        st_r.aw_have && st_r.w_have && st_r.wst != WR_RESP && st_r.wstrb0
            && st_r.awaddr == REFERENCE_CONTROL_ADDR;
    endsequence

    sequence dir_write_s;
        st_r.aw_have && st_r.w_have && st_r.wst != WR_RESP && st_r.wstrb0
            && st_r.awaddr == PORT_A_DIRECTION_ADDR;
    endsequence

    sequence ctl_read_s;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == REFERENCE_CONTROL_ADDR;
    endsequence

    power_follow_a: assert property (ctl_write_s |=> o_ladder_power_enable == $past(st_r.wdata[POWER_BIT]))
        else $error("power enable did not follow write");
    pin_gate_a: assert property (o_analog_output_pin_connect
            == (st_r.regs.control[PIN_OUT_BIT] & st_r.regs.direction[PIN2_BIT]))
        else $error("pin gate wrong");
    range_follow_a: assert property (ctl_write_s |=> o_ladder_range_low_select == $past(st_r.wdata[RANGE_BIT]))
        else $error("range select did not follow write");
    tap_follow_a: assert property (ctl_write_s |=> o_ladder_tap_code == $past(st_r.wdata[3:0]))
        else $error("tap code did not follow write");
    reset_clear_a: assert property (@(posedge i_clk) disable iff (1'b0)
            $past(i_rst) |-> st_r.regs.control == 8'h00 && !o_ladder_power_enable)
        else $error("reset did not clear control");
    wake_hold_a: assert property (i_sleep_wake && !(ctl_write_s) |=> $stable(st_r.regs.control))
        else $error("control changed on wake");
    unused_zero_a: assert property (!st_r.regs.control[UNUSED_BIT])
        else $error("bit 4 stored");
    outputs_stable_a: assert property (!(ctl_write_s) ##1 !(ctl_write_s) |=> $stable(o_ladder_tap_code))
        else $error("tap changed with no write");
    pin_dir_follow_a: assert property (dir_write_s |=>
            o_port_a_pin2_direction == $past(st_r.wdata[PIN2_BIT]))
        else $error("pin direction did not follow write");
    read_zero_a: assert property (ctl_read_s |=> !s_axi_rdata[UNUSED_BIT])
        else $error("bit 4 read as one");
    reset_out_a: assert property (@(posedge i_clk) disable iff (1'b0)
            $past(i_rst) |-> !o_analog_output_pin_connect && !o_ladder_range_low_select
            && o_ladder_tap_code == 4'h0 && !s_axi_bvalid && !s_axi_rvalid && !s_axi_arready)
        else $error("reset did not clear outputs");
    write_answer_a: assert property (ctl_write_s |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
        else $error("control write not answered");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule // ladder_reference_control
`default_nettype wire

// ===== verif/ladder_reference_control_tb.sv
/*
 testbench for ladder_reference_control: drives the AXI4-Lite slave and wake input,
 checks register contents and ladder outputs. assumes the package register map.
*/
`timescale 1ns/10ps
`default_nettype none
module ladder_reference_control_tb;
    import ladder_ref_pkg::*;
    logic i_clk, i_rst, i_sleep_wake;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, o_ladder_tap_code;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic o_ladder_power_enable, o_ladder_range_low_select, o_analog_output_pin_connect, o_port_a_pin2_direction;
    int err_count, n_tests, cyc;
    ladder_reference_control u_ladder_reference_control (.i_clk, .i_rst, .i_sleep_wake, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_ladder_power_enable,
        .o_ladder_range_low_select, .o_ladder_tap_code, .o_analog_output_pin_connect, .o_port_a_pin2_direction);
    ////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    function automatic logic [7:0] outs();
        return {o_ladder_power_enable, o_ladder_range_low_select, o_ladder_tap_code,
            o_analog_output_pin_connect, o_port_a_pin2_direction};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, b;
        b = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge i_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge i_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        @(posedge i_clk);
    endtask
    task automatic axr(input logic [11:0] a);
        logic ta, b;
        b = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!b) begin
            @(negedge i_clk);
            ta = s_axi_arvalid && s_axi_arready;
            b = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge i_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (b) s_axi_rready <= 1'b0;
        end
        @(posedge i_clk);
    endtask
    task automatic do_reset();
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        chk("outputs after reset", 32'h01, outs());
        axr(REFERENCE_CONTROL_ADDR);
        chk("control after reset", 32'h00, rd);
    endtask
    task automatic t_fields();
        axw(REFERENCE_CONTROL_ADDR, 32'hff);
        chk("write resp", RESP_OKAY, resp);
        chk("all set outputs", 32'hff, outs());
        axr(REFERENCE_CONTROL_ADDR);
        chk("unused bit read", 32'hef, rd);
        axw(PORT_A_DIRECTION_ADDR, 32'hfb);
        chk("pin as output", 32'hfc, outs());
        axw(PORT_A_DIRECTION_ADDR, 32'hff);
        axw(REFERENCE_CONTROL_ADDR, 32'hbf);
        chk("pin out disabled", 32'hfd, outs());
    endtask
    task automatic t_taps();
        for (int k = 0; k < 16; k++) begin
            axw(REFERENCE_CONTROL_ADDR, {24'h0, 4'h8, k[3:0]});
            repeat (2) @(posedge i_clk);
            chk("tap high range", {24'h0, 2'b10, k[3:0], 2'b01}, outs());
        end
    endtask
    task automatic t_wake();
        axw(REFERENCE_CONTROL_ADDR, 32'ha6);
        chk("low range outputs", 32'hd9, outs());
        axw(REFERENCE_CONTROL_ADDR, 32'h26);
        i_sleep_wake <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sleep_wake <= 1'b0;
        @(posedge i_clk);
        axr(REFERENCE_CONTROL_ADDR);
        chk("control after wake", 32'h26, rd);
        chk("outputs after wake", 32'h59, outs());
    endtask
    task automatic t_unmapped();
        axr(12'h100);
        chk("unmapped resp", RESP_SLVERR, resp);
        chk("unmapped data", 32'h0, rd);
        axw(12'h100, 32'hff);
        chk("unmapped write resp", RESP_SLVERR, resp);
        axw(REFERENCE_CONTROL_ADDR, 32'he5);
        s_axi_wstrb <= 4'h0;
        axw(REFERENCE_CONTROL_ADDR, 32'h00);
        s_axi_wstrb <= 4'h1;
        chk("masked write resp", RESP_OKAY, resp);
        axr(REFERENCE_CONTROL_ADDR);
        chk("masked write kept", 32'he5, rd);
    endtask
    task automatic complete_run();
        $display("errors %0d tests %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        {i_rst, i_sleep_wake, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'h1};
        {err_count, n_tests, cyc} = '0;
        do_reset();
        t_fields();
        t_taps();
        t_wake();
        t_unmapped();
        do_reset();
        complete_run();
    end
endmodule // ladder_reference_control_tb
`default_nettype wire
